// >>> inc/smrc_defs.vh
`ifndef SMRC_DEFS_VH
`define SMRC_DEFS_VH

// Register byte offsets
`define SMRC_OFF_CTRL      12'h000
`define SMRC_OFF_STATUS    12'h004
`define SMRC_OFF_RXDATA    12'h008
`define SMRC_OFF_TXDATA    12'h00c
`define SMRC_OFF_SETTINGS  12'h010
`define SMRC_OFF_NAV       12'h014
`define SMRC_OFF_MIXADDR   12'h018
`define SMRC_OFF_MIXDATA   12'h01c

// Control fields
`define SMRC_CTRL_ENABLE    0
`define SMRC_CTRL_STORE     1
`define SMRC_CTRL_BUS_LSB   4
`define SMRC_CTRL_BUS_MSB   6

// Settings fields
`define SMRC_SET_IN_LSB     0
`define SMRC_SET_IN_MSB     1
`define SMRC_SET_OUT_LSB    2
`define SMRC_SET_OUT_MSB    3
`define SMRC_SET_CLKEXT     4
`define SMRC_SET_PH1        5
`define SMRC_SET_PH2        6
`define SMRC_SET_MMUTE      7

// Level encodings
`define SMRC_LVL_LOW        2'h0
`define SMRC_LVL_P4DBU      2'h1
`define SMRC_LVL_M10DBV     2'h2

// MIDI status nibbles and numbers
`define SMRC_ST_NOTEOFF     4'h8
`define SMRC_ST_NOTEON      4'h9
`define SMRC_ST_CC          4'hb
`define SMRC_ST_PITCH       4'he
`define SMRC_CC_VOLUME      7'h07
`define SMRC_CC_PAN         7'h0a
`define SMRC_CC_VPOT        7'h10
`define SMRC_CH_PHONES      4'h0
`define SMRC_CH_OUT12       4'hf

// Surface note numbers
`define SMRC_N_REC          7'h00
`define SMRC_N_SOLO         7'h08
`define SMRC_N_MUTE         7'h10
`define SMRC_N_SEL          7'h18
`define SMRC_N_VPUSH        7'h20
`define SMRC_N_EQ           7'h2c
`define SMRC_N_BANKL        7'h2e
`define SMRC_N_BANKR        7'h2f
`define SMRC_N_CHL          7'h30
`define SMRC_N_CHR          7'h31
`define SMRC_N_F9           7'h38
`define SMRC_N_F10          7'h39
`define SMRC_N_DYN          7'h4f
`define SMRC_N_PGUP         7'h50
`define SMRC_N_PGDN         7'h51
`define SMRC_N_REW          7'h5b
`define SMRC_N_FFWD         7'h5c
`define SMRC_N_UP           7'h60
`define SMRC_N_DOWN         7'h61
`define SMRC_N_LEFT         7'h62
`define SMRC_N_RIGHT        7'h63

// Mixer layout
`define SMRC_ROW_INPUT      1'b0
`define SMRC_ROW_OUTPUT     1'b1
`define SMRC_UNITY          7'h40
`define SMRC_PAN_CENTER     7'h40
`define SMRC_FIFO_DEPTH     128

`endif

// >>> rtl/smrc_fifo.v
`timescale 1ns/1ps
`default_nettype none

module smrc_fifo #(
    parameter W = 8,
    parameter D = 128,
    parameter A = 7
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [A:0]   level
);
    reg [W-1:0] mem [0:D-1];
    reg [A:0]   wp_q;
    reg [A:0]   rp_q;

    assign level     = wp_q - rp_q;
    assign in_ready  = (level != D[A:0]);
    assign out_valid = (wp_q != rp_q);
    assign out_data  = mem[rp_q[A-1:0]];

    always @(posedge clk)
    begin
        if (in_valid && in_ready)
            mem[wp_q[A-1:0]] <= in_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q <= {(A+1){1'b0}};
            rp_q <= {(A+1){1'b0}};
        end
        else
        begin
            if (in_valid && in_ready)
                wp_q <= wp_q + 1'b1;
            if (out_valid && out_ready)
                rp_q <= rp_q + 1'b1;
        end
    end
endmodule // smrc_fifo

`default_nettype wire

// >>> rtl/smrc_top.v
// Summary of operation
// [R1] Mode changes only via stored enable flag
// [R2] Enabled: react to notes, send note feedback
// [R3] Software-only functions have no effect
// [R4] Navigation skips the playback row
// [R5] Always submix view; stored bus at start
// [R6] Send brief display, pan, LED data; code only echoes each received byte while enabled
// [R7] Faders volume, select+unity_reset_modifier unity, pots pan
// [R8] Window moves by one, eight, or row
// [R9] Master mute, mute, select, bus choose
// [R10] Solo 1-3 input, 7-8 clock, F9/F10 phantom
// [R11] Solo 4-6 set output level
// [R12] CC7 volume, CC10 pan accepted
// [R13] Output row: phones ch1, out1+2 ch16
// [R14] Input n on MIDI channel n+1
// [R15] 128-byte receive and transmit FIFOs
// [R16] Control change: status, number, value
// [R17] Channel nibble is channel minus one
// [R18] Unmapped messages ignored silently
// [R19] Values 0-127 map to full range
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.vh"

module smrc_top #(
    parameter NCH   = 16,
    parameter DEPTH = `SMRC_FIFO_DEPTH
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        stored_enable,
    input  wire [2:0]  stored_bus,
    input  wire        cfg_valid,
    input  wire [7:0]  rx_byte,
    input  wire        rx_valid,
    output reg         rx_ready,
    output reg  [7:0]  tx_byte,
    output reg         tx_valid,
    input  wire        tx_ready,
    output reg         remote_active,
    output reg  [1:0]  input_level,
    output reg  [1:0]  output_level,
    output reg         follow_external_clock,
    output reg         phantom1,
    output reg         phantom2,
    output reg         master_mute
);
    localparam S_IDLE = 2'd0;
    localparam S_NUM  = 2'd1;
    localparam S_VAL  = 2'd2;

    reg        en_q, cfg_q;
    reg  [2:0] bus_q;
    reg  [1:0] st_q;
    reg  [3:0] kind_q, chn_q;
    reg  [6:0] num_q;
    reg  [3:0] col_q;
    reg        row_q;
    reg  [1:0] in_lvl_q, out_lvl_q;
    reg        ext_q, ph1_q, ph2_q, mm_q, dyn_q;
    reg  [6:0] vol [0:31];
    reg  [6:0] pan [0:15];
    reg [15:0] mute_q, sel_q;
    reg  [4:0] madr_q;

    wire [7:0] rxf_data, txf_data;
    wire       rxf_valid, txf_in_ready, txf_valid;
    wire [7:0] rx_lvl, tx_lvl;
    reg  [7:0] fb_d;
    reg        fb_v_d;
    wire       rx_take = rxf_valid && txf_in_ready;
    // Output register loads and pops the queue together
    wire       tx_load = !tx_valid || tx_ready;
    // Flash request: enable and bus committed at once
    wire       ctrl_store = psel && penable && pwrite && paddr == `SMRC_OFF_CTRL
                            && pwdata[`SMRC_CTRL_STORE];

    smrc_fifo #(.W(8), .D(DEPTH), .A(7)) u_rx ( // [R15]
        .clk       (pclk),
        .rst_n     (presetn),
        .in_data   (rx_byte),
        .in_valid  (rx_valid && rx_ready),
        .in_ready  (),
        .out_data  (rxf_data),
        .out_valid (rxf_valid),
        .out_ready (rx_take),
        .level     (rx_lvl)
    );

    smrc_fifo #(.W(8), .D(DEPTH), .A(7)) u_tx ( // [R15]
        .clk       (pclk),
        .rst_n     (presetn),
        .in_data   (fb_d),
        .in_valid  (fb_v_d),
        .in_ready  (txf_in_ready),
        .out_data  (txf_data),
        .out_valid (txf_valid),
        .out_ready (tx_load && en_q),
        .level     (tx_lvl)
    );

    // Press flag and channel slot of current message
    wire       is_note = (kind_q == `SMRC_ST_NOTEON) && rxf_data[6:0] != 7'h00;
    wire [2:0] btn = num_q[2:0];
    wire [3:0] wch = col_q + {1'b0, btn};

    // Feedback byte: each received byte echoed unchanged while enabled [R2] [R6]
    always @*
    begin
        fb_d   = 8'h00;
        fb_v_d = 1'b0;
        if (en_q && rx_take)
        begin
            fb_d   = rxf_data;
            fb_v_d = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 1'b0;
            cfg_q <= 1'b0;
            bus_q <= 3'h0;
            st_q <= S_IDLE;
            kind_q <= 4'h0;
            chn_q <= 4'h0;
            num_q <= 7'h00;
            col_q <= 4'h0;
            row_q <= `SMRC_ROW_INPUT;
            in_lvl_q <= `SMRC_LVL_P4DBU;
            out_lvl_q <= `SMRC_LVL_P4DBU;
            ext_q <= 1'b0;
            ph1_q <= 1'b0;
            ph2_q <= 1'b0;
            mm_q <= 1'b0;
            dyn_q <= 1'b0;
            mute_q <= 16'h0000;
            sel_q <= 16'h0000;
            madr_q <= 5'h00;
        end
        else
        begin
            cfg_q <= cfg_valid;
            if (cfg_valid && !cfg_q)
            begin
                en_q  <= stored_enable;        // [R1]
                bus_q <= stored_bus;           // [R5]
            end
            else if (ctrl_store)
            begin
                en_q  <= pwdata[`SMRC_CTRL_ENABLE]; // [R1]
                bus_q <= pwdata[`SMRC_CTRL_BUS_MSB:`SMRC_CTRL_BUS_LSB]; // [R5]
            end
            if (psel && penable && pwrite && paddr == `SMRC_OFF_MIXADDR)
                madr_q <= pwdata[4:0];
            if (rx_take && en_q)
            begin
                if (rxf_data[7]) // [R16]
                begin
                    kind_q <= rxf_data[7:4];
                    chn_q  <= rxf_data[3:0]; // [R17]
                    st_q   <= S_NUM;
                end
                else
                    case (st_q)
                    S_NUM:
                    begin
                        num_q <= rxf_data[6:0];
                        st_q  <= S_VAL;
                    end
                    S_VAL:
                    begin
                        st_q <= S_NUM;
                        if (kind_q == `SMRC_ST_CC) // [R12]
                        begin
                            if (chn_q == `SMRC_CH_PHONES && num_q == `SMRC_CC_VOLUME)
                                vol[16] <= rxf_data[6:0]; // [R13] [R19]
                            else if (chn_q == `SMRC_CH_OUT12 && num_q == `SMRC_CC_VOLUME)
                                vol[17] <= rxf_data[6:0]; // [R13]
                            else if (chn_q != `SMRC_CH_PHONES && chn_q != `SMRC_CH_OUT12)
                            begin
                                if (num_q == `SMRC_CC_VOLUME)
                                    vol[{1'b0, chn_q - 4'h1}] <= rxf_data[6:0]; // [R14]
                                else if (num_q == `SMRC_CC_PAN)
                                    pan[chn_q - 4'h1] <= rxf_data[6:0]; // [R14] [R19]
                            end
                            if (num_q[6:3] == 4'h2 && row_q == `SMRC_ROW_INPUT)
                                pan[col_q + {1'b0, num_q[2:0]}] <= rxf_data[6:0]; // [R7]
                        end
                        else if (kind_q == `SMRC_ST_PITCH && chn_q[3] == 1'b0)
                            vol[{row_q, col_q + chn_q}] <= rxf_data[6:0]; // [R7]
                        else if (kind_q == `SMRC_ST_NOTEOFF || kind_q == `SMRC_ST_NOTEON)
                        begin
                            if (num_q == `SMRC_N_DYN)
                                dyn_q <= is_note;
                            if (is_note) // [R2]
                            begin
                                case (num_q[6:3])
                                4'h0: bus_q <= btn;                        // [R5] [R9]
                                4'h1:
                                    case (btn) // [R10] [R11]
                                    3'd0: in_lvl_q  <= `SMRC_LVL_LOW;
                                    3'd1: in_lvl_q  <= `SMRC_LVL_P4DBU;
                                    3'd2: in_lvl_q  <= `SMRC_LVL_M10DBV;
                                    3'd3: out_lvl_q <= `SMRC_LVL_LOW;
                                    3'd4: out_lvl_q <= `SMRC_LVL_P4DBU;
                                    3'd5: out_lvl_q <= `SMRC_LVL_M10DBV;
                                    3'd6: ext_q     <= 1'b1;
                                    default: ext_q  <= 1'b0;
                                    endcase
                                4'h2: mute_q[wch] <= ~mute_q[wch];          // [R9]
                                4'h3:
                                begin
                                    sel_q[wch] <= ~sel_q[wch];              // [R9]
                                    if (dyn_q)
                                        vol[{row_q, wch}] <= `SMRC_UNITY;   // [R7]
                                end
                                4'h4: pan[wch] <= `SMRC_PAN_CENTER;         // [R7]
                                default:
                                    case (num_q) // [R8] [R4]
                                    `SMRC_N_EQ: mm_q <= ~mm_q;              // [R9]
                                    `SMRC_N_F9: ph1_q <= ~ph1_q;            // [R10]
                                    `SMRC_N_F10: ph2_q <= ~ph2_q;
                                    `SMRC_N_CHL, `SMRC_N_REW: col_q <= col_q - 4'h1;
                                    `SMRC_N_CHR, `SMRC_N_FFWD: col_q <= col_q + 4'h1;
                                    `SMRC_N_BANKL, `SMRC_N_LEFT: col_q <= col_q - 4'h8;
                                    `SMRC_N_BANKR, `SMRC_N_RIGHT: col_q <= col_q + 4'h8;
                                    `SMRC_N_UP, `SMRC_N_PGUP: row_q <= `SMRC_ROW_INPUT;
                                    `SMRC_N_DOWN, `SMRC_N_PGDN: row_q <= `SMRC_ROW_OUTPUT;
                                    default: ; // [R3] [R18]
                                    endcase
                                endcase
                            end
                        end
                    end
                    default: ; // [R18]
                    endcase
            end
        end
    end

    // Outputs and APB slave
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            rx_ready <= 1'b0;
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
            remote_active <= 1'b0;
            input_level <= `SMRC_LVL_P4DBU;
            output_level <= `SMRC_LVL_P4DBU;
            follow_external_clock <= 1'b0;
            phantom1 <= 1'b0;
            phantom2 <= 1'b0;
            master_mute <= 1'b0;
        end
        else
        begin
            // Room kept for the byte already in flight
            rx_ready <= (rx_lvl <= (DEPTH[7:0] - 8'h02)); // [R15]
            if (tx_load)
            begin
                tx_valid <= txf_valid && en_q; // [R2]
                tx_byte  <= txf_data;
            end
            remote_active <= en_q;
            input_level <= in_lvl_q;
            output_level <= out_lvl_q;
            follow_external_clock <= ext_q;
            phantom1 <= ph1_q;
            phantom2 <= ph2_q;
            master_mute <= mm_q;
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                pslverr <= 1'b0;
                case (paddr)
                `SMRC_OFF_CTRL:     prdata <= {25'h0, bus_q, 3'h0, en_q};
                `SMRC_OFF_STATUS:   prdata <= {8'h0, tx_lvl, rx_lvl, 7'h0, en_q};
                `SMRC_OFF_SETTINGS: prdata <= {24'h0, mm_q, ph2_q, ph1_q, ext_q,
                                               out_lvl_q, in_lvl_q};
                `SMRC_OFF_NAV:      prdata <= {23'h0, row_q, 4'h0, col_q};
                `SMRC_OFF_MIXADDR:  prdata <= {27'h0, madr_q};
                `SMRC_OFF_MIXDATA:  prdata <= {8'h0, sel_q[madr_q[3:0]],
                                               mute_q[madr_q[3:0]], 6'h0,
                                               1'b0, pan[madr_q[3:0]],
                                               1'b0, vol[madr_q]};
                default:
                begin
                    prdata  <= 32'h00000000;
                    pslverr <= 1'b1;
                end
                endcase
            end
        end
    end
endmodule // smrc_top

`default_nettype wire

// >>> bench/smrc_props.sv
`timescale 1ns/1ps
`default_nettype none

module smrc_props (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       stored_enable,
    input wire logic       cfg_valid,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       remote_active,
    input wire logic [1:0] input_level,
    input wire logic [1:0] output_level,
    input wire logic       follow_external_clock,
    input wire logic       phantom1,
    input wire logic       phantom2,
    input wire logic       master_mute
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    in_level_legal_a: assert property (input_level != 2'h3)
        else $error("input level code out of range");
    out_level_legal_a: assert property (output_level != 2'h3)
        else $error("output level code out of range");
    disabled_hold_a: assert property (!remote_active && !(psel && pwrite) |=>
        $stable({input_level, output_level, follow_external_clock, phantom1, phantom2,
        master_mute})) else $error("setting changed while remote control is off");
    enable_seen_a: assert property ($rose(cfg_valid) && stored_enable |->
        ##[0:4] remote_active) else $error("stored enable not taken");
    access_ready_a: assert property (psel && !penable ##1 psel && penable |-> pready)
        else $error("no ready in access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held past access");
    err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error flag outside access");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("transmit byte dropped while stalled");
endmodule // smrc_props

bind smrc_top smrc_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .stored_enable(stored_enable), .cfg_valid(cfg_valid), .tx_byte(tx_byte),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .remote_active(remote_active),
    .input_level(input_level), .output_level(output_level),
    .follow_external_clock(follow_external_clock), .phantom1(phantom1),
    .phantom2(phantom2), .master_mute(master_mute));

`default_nettype wire

// >>> bench/smrc_surface.sv
`timescale 1ns/1ps
`default_nettype none

module smrc_surface (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       slow,
    output var logic [7:0] rx_byte,
    output var logic       rx_valid,
    input wire logic       rx_ready,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_valid,
    output var logic       tx_ready
);
    logic [7:0] sent_q[$];
    logic [7:0] got_q[$];

    initial
    begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end

    // Collect feedback; slow mode stalls every other cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_ready <= 1'b0;
        else
        begin
            if (tx_valid === 1'b1 && tx_ready === 1'b1)
                got_q.push_back(tx_byte);
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
    end

    task send(input logic [7:0] b);
        @(posedge pclk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        sent_q.push_back(b);
        do @(posedge pclk); while (rx_ready !== 1'b1);
        rx_valid <= 1'b0;
        rx_byte <= ~b;
    endtask

    task send_note(input logic [6:0] n, input logic [6:0] v);
        send({4'h9, 4'h0});
        send({1'b0, n});
        send({1'b0, v});
    endtask

    task send_cc(input logic [4:0] ch, input logic [6:0] n, input logic [6:0] v);
        send({4'hb, ch[3:0] - 4'h1});
        send({1'b0, n});
        send({1'b0, v});
    endtask
endmodule // smrc_surface

`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.vh"

module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        stored_enable, cfg_valid, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [2:0]  stored_bus;
    logic [7:0]  rx_byte, tx_byte;
    logic        remote_active, follow_external_clock, phantom1, phantom2, master_mute;
    logic [1:0]  input_level, output_level;
    logic [8:0]  exp;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    smrc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .stored_enable, .stored_bus, .cfg_valid, .rx_byte, .rx_valid,
        .rx_ready, .tx_byte, .tx_valid, .tx_ready, .remote_active, .input_level,
        .output_level, .follow_external_clock, .phantom1, .phantom2, .master_mute);
    smrc_surface i_surf (.pclk, .presetn, .slow, .rx_byte, .rx_valid, .rx_ready,
        .tx_byte, .tx_valid, .tx_ready);

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task stop_test;
        $display("checks=%0d errors=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function logic [31:0] state();
        return {23'h0, remote_active, master_mute, phantom2, phantom1,
            follow_external_clock, output_level, input_level};
    endfunction

    // Press and release, then wait for the echo to drain
    task note(input logic [6:0] n);
        int i;
        i_surf.send_note(n, 7'h7f);
        i_surf.send_note(n, 7'h00);
        for (i = 0; i < 200 && i_surf.got_q.size() != i_surf.sent_q.size(); i++)
            @(posedge pclk);
        repeat (4) @(posedge pclk);
    endtask

    task t_reset;
        check(state(), 32'h005);
        apb(1'b0, `SMRC_OFF_SETTINGS, 32'h0);
        check(rd, 32'h5);
        apb(1'b1, 12'h020, 32'h1234);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        check({rd[30:0], err}, 32'h1);
    endtask

    task t_disabled;
        note(`SMRC_N_SOLO);
        check(state(), 32'h005);
        check(i_surf.got_q.size(), 0);
        i_surf.got_q.delete();
        i_surf.sent_q.delete();
    endtask

    task t_enable;
        stored_enable <= 1'b1;
        stored_bus <= 3'h5;
        @(posedge pclk);
        cfg_valid <= 1'b1;
        repeat (4) @(posedge pclk);
        cfg_valid <= 1'b0;
        check(state(), 32'h105);
        apb(1'b0, `SMRC_OFF_CTRL, 32'h0);
        check(rd, 32'h51);
    endtask

    task t_solo;
        int k;
        exp = 9'h105;
        for (k = 0; k < 8; k++)
        begin
            case (k)
                0: exp[1:0] = `SMRC_LVL_LOW;
                1: exp[1:0] = `SMRC_LVL_P4DBU;
                2: exp[1:0] = `SMRC_LVL_M10DBV;
                3: exp[3:2] = `SMRC_LVL_LOW;
                4: exp[3:2] = `SMRC_LVL_P4DBU;
                5: exp[3:2] = `SMRC_LVL_M10DBV;
                6: exp[4] = 1'b1;
                default: exp[4] = 1'b0;
            endcase
            note(`SMRC_N_SOLO + 7'(k));
            check(state(), {23'h0, exp});
        end
    endtask

    task t_toggles;
        note(`SMRC_N_F9);
        exp[5] = 1'b1;
        check(state(), {23'h0, exp});
        note(`SMRC_N_F10);
        exp[6] = 1'b1;
        check(state(), {23'h0, exp});
        note(`SMRC_N_F10);
        exp[6] = 1'b0;
        check(state(), {23'h0, exp});
        note(`SMRC_N_EQ);
        exp[7] = 1'b1;
        check(state(), {23'h0, exp});
        note(7'h5e);
        i_surf.send_cc(5'd1, 7'h66, 7'h40);
        note(7'h7e);
        check(state(), {23'h0, exp});
        apb(1'b0, `SMRC_OFF_SETTINGS, 32'h0);
        check(rd, 32'haa);
    endtask

    task t_echo;
        int i;
        slow <= 1'b1;
        i_surf.send_cc(5'd2, `SMRC_CC_VOLUME, 7'h40);
        i_surf.send_cc(5'd16, `SMRC_CC_VOLUME, 7'h7f);
        i_surf.send_cc(5'd15, `SMRC_CC_PAN, 7'h00);
        note(`SMRC_N_BANKR);
        apb(1'b0, `SMRC_OFF_NAV, 32'h0);
        check(rd, 32'h008);
        note(`SMRC_N_DOWN);
        note(`SMRC_N_PGDN);
        apb(1'b0, `SMRC_OFF_NAV, 32'h0);
        check(rd, 32'h108);
        note(`SMRC_N_UP);
        apb(1'b0, `SMRC_OFF_NAV, 32'h0);
        check(rd, 32'h008);
        apb(1'b1, `SMRC_OFF_MIXADDR, 32'h0);
        apb(1'b0, `SMRC_OFF_MIXDATA, 32'h0);
        check({25'h0, rd[6:0]}, 32'h40);
        apb(1'b1, `SMRC_OFF_MIXADDR, 32'h11);
        apb(1'b0, `SMRC_OFF_MIXDATA, 32'h0);
        check({25'h0, rd[6:0]}, 32'h7f);
        apb(1'b1, `SMRC_OFF_MIXADDR, 32'hd);
        apb(1'b0, `SMRC_OFF_MIXDATA, 32'h0);
        check({25'h0, rd[14:8]}, 32'h0);
        check(i_surf.got_q.size(), i_surf.sent_q.size());
        for (i = 0; i < i_surf.sent_q.size() && i < i_surf.got_q.size(); i++)
            check(i_surf.got_q[i], i_surf.sent_q[i]);
        slow <= 1'b0;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        stored_enable = 1'b0;
        stored_bus = 3'h0;
        cfg_valid = 1'b0;
        slow = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_disabled();
        t_enable();
        t_solo();
        t_toggles();
        t_echo();
        stop_test();
    end
endmodule // testbench

`default_nettype wire
